// ==== bench/srrs_fw_model.sv ====
// Firmware-side model that emulates the modem and the data path events
`timescale 1ns/1ps
module srrs_fw_model (
  input wire logic mclk,
  output srrs_pkg::srrs_fw_s fw,
  output logic [4:0] txCnt,
  output logic [4:0] rxCnt
);
  import srrs_pkg::*;
  // ---------------------------------------------
  // Idle firmware: no events, path off, lines low
  // ---------------------------------------------
  initial begin
    fw = '0;
    txCnt = 5'h00;
    rxCnt = 5'h00;
  end
  // One-cycle event strobe; b indexes the event group
  task automatic pulse(input int b);
    @(negedge mclk);
    fw[b] = 1'h1;
    @(negedge mclk);
    fw[b] = 1'h0;
  endtask : pulse
  // Levels: path enable, modem lines, FIFO fill counts
  task automatic level(input logic e, input logic [3:0] m,
                       input logic [4:0] t, input logic [4:0] r);
    @(negedge mclk);
    fw.txPathEnable = e;
    fw.modemLines = m;
    txCnt = t;
    rxCnt = r;
  endtask : level
endmodule : srrs_fw_model

// ==== bench/test_srrs_status_regs.sv ====
// Self-checking bench for the console port status registers
`timescale 1ns/1ps
module test_srrs_status_regs;
  import srrs_pkg::*;
  localparam logic RD = 1'h0;
  localparam logic WR = 1'h1;
  localparam logic [2:0] LS = OFS_LINE_STATUS;
  localparam logic [2:0] MS = OFS_MODEM_STATUS;
  localparam logic [2:0] SC = OFS_SCRATCH;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic d3ToD0 = 1'h0;
  logic fifoModeIn = 1'h0;
  logic loopbackActive;
  logic fifoFlush;
  logic [4:0] txCnt;
  logic [4:0] rxCnt;
  logic [7:0] rdata;
  srrs_host_s host = '0;
  srrs_fw_s fw;
  int numErrors = 0;
  int compares = 0;
  srrs_fw_model srrs_fw_model_i (.mclk(mclk), .fw(fw), .txCnt(txCnt),
    .rxCnt(rxCnt));
  srrs_status_regs srrs_status_regs_i (.mclk(mclk), .rst(rst),
    .d3ToD0(d3ToD0), .host(host), .fw(fw), .txFifoCount(txCnt),
    .rxFifoCount(rxCnt), .fifoModeIn(fifoModeIn), .rdata(rdata),
    .loopbackActive(loopbackActive), .fifoFlush(fifoFlush));
  // 200 MHz clock
  initial forever #2.5 mclk = ~mclk;
  // Byte compare, counted
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  // Host access held for one edge; read data is checked a cycle later
  task automatic rw(input logic w, input logic [2:0] a,
                    input logic [7:0] d, input logic chk = 1'h1);
    @(negedge mclk);
    host = '{~w, w, a, w ? d : 8'h00};
    @(negedge mclk);
    host = '0;
    if (!w && chk) cmp(rdata, d);
  endtask : rw
  // Counts, verdict and end of run
  task automatic print_verdict;
    $display("compares %0d errors %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  // Hang guard
  initial begin
    #100us;
    numErrors++;
    print_verdict();
  end
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    repeat (8) @(negedge mclk);
    rst = 1'h0;
    rw(RD, LS, 8'h00);
    rw(RD, MS, 8'h00);
    rw(RD, SC, 8'h00);
    rw(WR, SC, 8'hA5);
    rw(RD, SC, 8'hA5);
    rw(RD, 3'h2, 8'h00);
    srrs_fw_model_i.level(1'h1, 4'h0, 5'h00, 5'h00);
    srrs_fw_model_i.pulse(8);
    rw(RD, LS, 8'h60);
    rw(WR, 3'h0, 8'h55);
    rw(RD, LS, 8'h00);
    srrs_fw_model_i.pulse(8);
    srrs_fw_model_i.pulse(6);
    srrs_fw_model_i.pulse(5);
    rw(RD, LS, 8'h72);
    rw(RD, LS, 8'h60);
    srrs_fw_model_i.pulse(9);
    rw(RD, LS, 8'h61);
    rw(RD, 3'h0, 8'h00, 1'h0);
    rw(RD, LS, 8'h60);
    srrs_fw_model_i.level(1'h0, 4'h0, 5'h00, 5'h00);
    rw(RD, LS, 8'h00);
    $display("non-FIFO line status test done");
    srrs_fw_model_i.level(1'h1, 4'h0, 5'h03, 5'h02);
    fifoModeIn = 1'h1;
    #1;
    cmp({7'h00, fifoFlush}, 8'h01);
    @(negedge mclk);
    cmp({7'h00, fifoFlush}, 8'h00);
    rw(RD, LS, 8'h01);
    srrs_fw_model_i.pulse(7);
    rw(RD, LS, 8'h91);
    rw(RD, LS, 8'h01);
    srrs_fw_model_i.level(1'h1, 4'h0, 5'h03, 5'h00);
    rw(RD, LS, 8'h00);
    fifoModeIn = 1'h0;
    rw(RD, LS, 8'h60);
    $display("FIFO line status test done");
    srrs_fw_model_i.level(1'h1, 4'hA, 5'h00, 5'h00);
    rw(RD, MS, 8'hAA);
    rw(RD, MS, 8'hA0);
    srrs_fw_model_i.level(1'h1, 4'h1, 5'h00, 5'h00);
    rw(RD, MS, 8'h1B);
    srrs_fw_model_i.level(1'h1, 4'h5, 5'h00, 5'h00);
    rw(RD, MS, 8'h50);
    srrs_fw_model_i.level(1'h1, 4'h1, 5'h00, 5'h00);
    rw(RD, MS, 8'h14);
    rw(WR, OFS_MODEM_CONTROL, 8'h19);
    rw(RD, MS, 8'hAB);
    cmp({7'h00, loopbackActive}, 8'h01);
    $display("modem status test done");
    @(negedge mclk);
    d3ToD0 = 1'h1;
    @(negedge mclk);
    d3ToD0 = 1'h0;
    rw(RD, SC, 8'h00);
    $display("power return test done");
    print_verdict();
  end
endmodule : test_srrs_status_regs

// ==== common/srrs_pkg.sv ====
// Package of constants and types for the serial redirect status registers
// Function
// RQ1: RX FIFO error zero, else follows break
// RQ2: Transmitter empty mirrors holding empty
// RQ3: Mode switch sets holding empty
// RQ4: Holding empty only while firmware enables path
// RQ5: Non-FIFO: host write clears, firmware read sets
// RQ6: FIFO: holding empty tracks TX FIFO empty
// RQ7: Line status read clears break
// RQ8: Firmware break flag sets break
// RQ9: Framing and parity bits read zero
// RQ10: Firmware sets overrun; status read clears
// RQ11: Non-FIFO: firmware write sets, host read clears
// RQ12: FIFO: data ready tracks RX FIFO nonempty
// RQ13: Reset or D3 to D0 zeroes registers
// RQ14: Loopback maps control bits to status
// RQ15: Carrier change sets delta carrier
// RQ16: Ring falling edge sets trailing flag
// RQ17: Set-ready change sets delta flag
// RQ18: Clear-send change sets delta flag
// RQ19: Modem status read clears delta flags
// RQ20: Scratch is plain 8-bit store
// RQ21: Control bit 4 selects loopback
// RQ22: FIFO control bit 0 selects FIFO mode
// RQ23: Outside loopback show firmware modem lines
package srrs_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_MODEM_CONTROL = 3'h4;
  localparam logic [2:0] OFS_LINE_STATUS = 3'h5;
  localparam logic [2:0] OFS_MODEM_STATUS = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int LOOPBACK_SELECT_BIT = 4;
  localparam int FIFO_MODE_SELECT_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Host access strobe group
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } srrs_host_s;
  // Firmware event group, all one-cycle strobes except path enable and lines
  typedef struct packed {
    logic rxWrite;
    logic txRead;
    logic fifoBreakSet;
    logic bufferBreakAssert;
    logic overrunSet;
    logic txPathEnable;
    logic [3:0] modemLines;
  } srrs_fw_s;
endpackage : srrs_pkg

// ==== rtl/srrs_delta_detect.sv ====
// Change detector for the four emulated modem input lines
`timescale 1ns/1ps
module srrs_delta_detect (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] lines,
  input wire logic clearAll,
  output logic [3:0] deltas
);
  import srrs_pkg::*;
  // ----------------------------------------------------------------
  // Previous line values and sticky deltas
  // ----------------------------------------------------------------
  logic [3:0] prev_q; // Lines one cycle ago
  logic [3:0] delta_q; // Sticky flags
  wire [3:0] chg = lines ^ prev_q; // Any change
  // Bit 2 is ring: falling edge only
  wire [3:0] evt = {chg[3], prev_q[2] & ~lines[2], chg[1], chg[0]}; // RQ16
  // Sticky; set wins over a read clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      prev_q <= 4'h0;
      delta_q <= 4'h0;
    end else begin
      prev_q <= lines;
      delta_q <= (clearAll ? 4'h0 : delta_q) | evt; // RQ15 RQ17 RQ18 RQ19
    end
  end
  assign deltas = delta_q;
endmodule : srrs_delta_detect

// ==== rtl/srrs_status_regs.sv ====
// Line status, modem status and scratch registers of the console port
`timescale 1ns/1ps
module srrs_status_regs #(
  parameter int TX_FIFO_DEPTH = 16, // Firmware-side FIFO depth
  parameter int RX_FIFO_DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic d3ToD0, // Power state return strobe
  input wire srrs_pkg::srrs_host_s host,
  input wire srrs_pkg::srrs_fw_s fw,
  input wire logic [4:0] txFifoCount, // Bytes held in TX FIFO
  input wire logic [4:0] rxFifoCount, // Bytes held in RX FIFO
  input wire logic fifoModeIn, // FIFO control bit 0 as written
  output logic [7:0] rdata,
  output logic loopbackActive,
  output logic fifoFlush
);
  import srrs_pkg::*;
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire clr = rst | d3ToD0; // RQ13
  wire rdLineStat = host.rd && host.addr == OFS_LINE_STATUS;
  wire rdModemStat = host.rd && host.addr == OFS_MODEM_STATUS;
  wire wrModemCtl = host.wr && host.addr == OFS_MODEM_CONTROL;
  wire wrScratch = host.wr && host.addr == OFS_SCRATCH;
  wire wrTxHold = host.wr && host.addr == OFS_DATA; // Holding write
  wire rdRxBuf = host.rd && host.addr == OFS_DATA; // Receive buffer
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [4:0] modemCtl_q; // Modem control low bits
  logic [7:0] scratch_q; // Scratch store
  logic fifo_q; // Mode seen last cycle
  logic txHoldEmpty_q; // Holding empty, before path gating
  logic rxReady_q; // Data ready
  logic brk_q; // Sticky break
  logic ovr_q; // Sticky overrun
  logic [3:0] deltas;
  wire fifoMode = fifoModeIn; // RQ22
  wire modeChg = fifoMode != fifo_q;
  assign loopbackActive = modemCtl_q[LOOPBACK_SELECT_BIT]; // RQ21
  assign fifoFlush = modeChg; // RQ22
  // Loopback: status 7..4 <= control 3,2,0,1
  wire [3:0] modemLines = loopbackActive ?
    {modemCtl_q[3], modemCtl_q[2], modemCtl_q[0], modemCtl_q[1]} :
    fw.modemLines; // RQ14 RQ23
  // ----------------------------------------------------------------
  // Flag updates
  // ----------------------------------------------------------------
  // Mode switch wins for one cycle, then the FIFO count or, in non-FIFO mode, the strobes take over
  wire txHoldEmpty_d = modeChg ? 1'h1 : // RQ3
    fifoMode ? (txFifoCount == 5'h00) : // RQ6
    fw.txRead ? 1'h1 : wrTxHold ? 1'h0 : txHoldEmpty_q; // RQ5
  wire rxReady_d = fifoMode ? (rxFifoCount != 5'h00) : // RQ12
    fw.rxWrite ? 1'h1 : rdRxBuf ? 1'h0 : rxReady_q; // RQ11
  wire brkSet = fifoMode ? fw.fifoBreakSet : fw.bufferBreakAssert; // RQ8
  // Register updates; a set in the read cycle survives the clear
  always_ff @(posedge mclk) begin
    if (clr) begin
      modemCtl_q <= 5'h00;
      scratch_q <= REG_RESET;
      fifo_q <= 1'h0;
      txHoldEmpty_q <= 1'h0;
      rxReady_q <= 1'h0;
      brk_q <= 1'h0;
      ovr_q <= 1'h0;
    end else begin
      if (wrModemCtl) modemCtl_q <= host.wdata[4:0];
      if (wrScratch) scratch_q <= host.wdata; // RQ20
      fifo_q <= fifoMode;
      txHoldEmpty_q <= txHoldEmpty_d;
      rxReady_q <= rxReady_d;
      brk_q <= brkSet | (brk_q & ~rdLineStat); // RQ7
      ovr_q <= fw.overrunSet | (ovr_q & ~rdLineStat); // RQ10
    end
  end
  srrs_delta_detect u_delta (
    .mclk(mclk),
    .rst(clr),
    .lines(modemLines),
    .clearAll(rdModemStat), // RQ19
    .deltas(deltas)
  );
  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Holding empty is hidden while firmware keeps the path off
  wire txHoldVis = txHoldEmpty_q & fw.txPathEnable; // RQ4
  wire [7:0] lineStat = {fifoMode & brk_q, txHoldVis, txHoldVis, // RQ1 RQ2
    brk_q, 2'h0, ovr_q, rxReady_q}; // RQ9
  wire [7:0] modemStat = {modemLines, deltas};
  // Read data register; holds until the next host read
  always_ff @(posedge mclk) begin
    if (clr) rdata <= REG_RESET;
    else if (rdLineStat) rdata <= lineStat;
    else if (rdModemStat) rdata <= modemStat;
    else if (host.rd && host.addr == OFS_SCRATCH) rdata <= scratch_q;
    else if (host.rd && host.addr == OFS_MODEM_CONTROL)
      rdata <= {3'h0, modemCtl_q};
    else if (host.rd) rdata <= 8'h00;
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  brk_clr_a: assert property (@(posedge mclk) disable iff (clr) // RQ7
    rdLineStat && !brkSet |=> !brk_q) else $error("break not cleared");
  ovr_clr_a: assert property (@(posedge mclk) disable iff (clr) // RQ10
    rdLineStat && !fw.overrunSet |=> !ovr_q) else $error("overrun kept");
  tx_empty_a: assert property (@(posedge mclk) lineStat[6] == lineStat[5])
    else $error("transmitter empty differs"); // RQ2
  mode_hold_a: assert property (@(posedge mclk) disable iff (clr) // RQ3
    modeChg |=> txHoldEmpty_q) else $error("holding empty not set");
  rxerr_a: assert property (@(posedge mclk) !fifoMode |-> !lineStat[7])
    else $error("rx error in non fifo"); // RQ1
  delta_clr_a: assert property (@(posedge mclk) disable iff (clr) // RQ19
    rdModemStat && $stable(modemLines) |=> deltas == 4'h0)
    else $error("delta");
  loop_map_a: assert property (@(posedge mclk) // RQ14
    loopbackActive |-> modemStat[7:4] ==
    {modemCtl_q[3:2], modemCtl_q[0], modemCtl_q[1]})
    else $error("loop map");
  ready_fifo_a: assert property (@(posedge mclk) disable iff (clr) // RQ12
    fifoMode && !modeChg |=> rxReady_q == ($past(rxFifoCount) != 5'h00))
    else $error("data ready");
  brk_c: cover property (@(posedge mclk) brkSet ##1 rdLineStat);
  loop_c: cover property (@(posedge mclk) loopbackActive && deltas != 4'h0);
  mode_c: cover property (@(posedge mclk) modeChg);
endmodule : srrs_status_regs
